// ===== cwxy_regs.svh
// register offsets, field positions and reset values of the compare / xy unit
// assumes an apb slave decoding the low 12 bits of paddr
`ifndef CWXY_REGS_SVH
`define CWXY_REGS_SVH

// ----------------------------------------------------------------------
// register map (byte addresses, low bits of the printed i/o addresses)
// ----------------------------------------------------------------------
`define PITCH_SHIFT_CONTROL_ADDR 32'hC000_0140
`define PIXEL_WIDTH_SETTING_ADDR 32'hC000_0150
`define WINDOW_LOW_CORNER_ADDR   32'h0000_0000
`define WINDOW_HIGH_CORNER_ADDR  32'h0000_0004
`define SCREEN_ORIGIN_ADDR       32'h0000_0008
`define STATUS_FLAGS_ADDR        32'h0000_000C
`define ADDR_DECODE_MASK         32'h0000_0FFF

// ----------------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------------
`define PITCH_SHIFT_RESET        16'h0014
`define PIXEL_WIDTH_RESET        16'h0001
`define PITCH_SHIFT_BASE         6'h1F
`define CODE_BIT_X_LOW           5
`define CODE_BIT_X_HIGH          6
`define CODE_BIT_Y_LOW           7
`define CODE_BIT_Y_HIGH          8

`endif

// ===== cwxy_pkg.sv
// types shared by the compare / xy unit and its operand port
// assumes cwxy_regs.svh is included wherever numbers are needed
`default_nettype none
package cwxy_pkg;
  // operation select
  typedef enum logic [3:0] {
    op_none                  = 4'b0000,
    compare_immediate_op     = 4'b0001,
    compare_packed_coords_op = 4'b0010,
    window_point_code_op     = 4'b0100,
    coords_to_linear_op      = 4'b1000
  } op_t;

  // condition flags
  typedef struct packed {
    logic n;
    logic c;
    logic z;
    logic v;
  } flags_t;

  // instruction request
  typedef struct packed {
    op_t         op;
    logic [15:0] imm_low_word;
    logic [15:0] imm_high_word;
    logic [31:0] source_register;
    logic [31:0] destination_value;
  } request_t;

  // result
  typedef struct packed {
    logic [31:0] value;
    logic        write_en;
    flags_t      flags;
  } result_t;
endpackage
`default_nettype wire

// ===== cwxy_window_code.sv
// point-code generator: signed xy point against inclusive window corners
// corners are compared as signed values like the point; negative corners give valid codes
`default_nettype none
`include "cwxy_regs.svh"
module cwxy_window_code (
  // operands
  input  wire logic [31:0] point,
  input  wire logic [31:0] low_corner,
  input  wire logic [31:0] high_corner,
  // result
  output logic      [31:0] code,
  output logic             outside
);
  // halves as signed fields
  wire logic signed [15:0] px = point[15:0];
  wire logic signed [15:0] py = point[31:16];
  wire logic signed [15:0] lx = low_corner[15:0];
  wire logic signed [15:0] ly = low_corner[31:16];
  wire logic signed [15:0] hx = high_corner[15:0];
  wire logic signed [15:0] hy = high_corner[31:16];

  // ----------------------------------------------------------------------
  // code assembly, unused bits forced to zero
  // ----------------------------------------------------------------------
  always_comb begin
    code = 32'h0000_0000;
    code[`CODE_BIT_X_LOW]  = lx > px;
    code[`CODE_BIT_X_HIGH] = px > hx;
    code[`CODE_BIT_Y_LOW]  = ly > py;
    code[`CODE_BIT_Y_HIGH] = py > hy;
  end
  assign outside = |code;
endmodule
`default_nettype wire

// ===== cwxy_unit.sv
// compare / window / xy-to-linear execution unit with apb register access
// assumes a single sys_clk domain; requests come from the issue logic
`default_nettype none
`include "cwxy_regs.svh"

module cwxy_unit (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // instruction request and result
  input  wire logic              req_valid,
  input  wire cwxy_pkg::request_t req,
  output logic                   res_valid,
  output cwxy_pkg::result_t      res
);
  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  logic [15:0] pitch_shift_control;
  logic [15:0] pixel_width_setting;
  logic [31:0] window_low_corner;
  logic [31:0] window_high_corner;
  logic [31:0] screen_origin;
  cwxy_pkg::flags_t flags;

  // address decode on the low bits
  wire logic [31:0] mask = `ADDR_DECODE_MASK;
  wire logic [31:0] a    = paddr & mask;
  wire logic hit_pitch = a == (`PITCH_SHIFT_CONTROL_ADDR & mask);
  wire logic hit_pix   = a == (`PIXEL_WIDTH_SETTING_ADDR & mask);
  wire logic hit_low   = a == `WINDOW_LOW_CORNER_ADDR;
  wire logic hit_high  = a == `WINDOW_HIGH_CORNER_ADDR;
  wire logic hit_orig  = a == `SCREEN_ORIGIN_ADDR;
  wire logic hit_flags = a == `STATUS_FLAGS_ADDR;
  wire logic hit_any   = hit_pitch | hit_pix | hit_low | hit_high | hit_orig | hit_flags;
  wire logic access    = psel & penable;
  wire logic wr_en     = access & pwrite & hit_any;

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~hit_any;

  // read data mux, narrow registers zero-extended
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_pitch) next_prdata = {16'h0000, pitch_shift_control};
    if (hit_pix)   next_prdata = {16'h0000, pixel_width_setting};
    if (hit_low)   next_prdata = window_low_corner;
    if (hit_high)  next_prdata = window_high_corner;
    if (hit_orig)  next_prdata = screen_origin;
    if (hit_flags) next_prdata = {28'h000_0000, flags};
  end
  // read data latched in the setup cycle so it comes from a flip-flop
  // and stands through the access phase; zero while the bus is idle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= next_prdata;
    end else if (~psel) begin
      prdata <= 32'h0000_0000;
    end
  end

  // register writes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pitch_shift_control <= `PITCH_SHIFT_RESET;
      pixel_width_setting <= `PIXEL_WIDTH_RESET;
      window_low_corner   <= 32'h0000_0000;
      window_high_corner  <= 32'h0000_0000;
      screen_origin       <= 32'h0000_0000;
    end else if (wr_en) begin
      if (hit_pitch) pitch_shift_control <= pwdata[15:0];
      if (hit_pix)   pixel_width_setting <= pwdata[15:0];
      if (hit_low)   window_low_corner   <= pwdata;
      if (hit_high)  window_high_corner  <= pwdata;
      if (hit_orig)  screen_origin       <= pwdata;
    end
  end

  // ----------------------------------------------------------------------
  // long immediate compare
  // ----------------------------------------------------------------------
  // operand words arrive as stored, i.e. ones complemented
  wire logic [31:0] long_immediate = ~{req.imm_high_word, req.imm_low_word};
  wire logic [32:0] imm_diff = {1'b0, req.destination_value} - {1'b0, long_immediate};
  wire logic [31:0] imm_res  = imm_diff[31:0];
  cwxy_pkg::flags_t imm_flags;
  always_comb begin
    imm_flags.n = imm_res[31];
    imm_flags.c = imm_diff[32];
    imm_flags.z = imm_res == 32'h0000_0000;
    imm_flags.v = (req.destination_value[31] ^ long_immediate[31])
                & (req.destination_value[31] ^ imm_res[31]);
  end

  // ----------------------------------------------------------------------
  // packed xy compare
  // ----------------------------------------------------------------------
  wire logic [15:0] x_diff = req.destination_value[15:0] - req.source_register[15:0];
  wire logic [15:0] y_diff = req.destination_value[31:16] - req.source_register[31:16];
  cwxy_pkg::flags_t xy_flags;
  always_comb begin
    xy_flags.n = req.destination_value[15:0] == req.source_register[15:0];
    xy_flags.c = y_diff[15];
    xy_flags.z = req.destination_value[31:16] == req.source_register[31:16];
    xy_flags.v = x_diff[15];
  end

  // ----------------------------------------------------------------------
  // window point code
  // ----------------------------------------------------------------------
  logic [31:0] point_code;
  logic        point_outside;
  // corners taken from the window registers, lesser and greater
  cwxy_window_code u_window_code (
    .point       (req.source_register),
    .low_corner  (window_low_corner),
    .high_corner (window_high_corner),
    .code        (point_code),
    .outside     (point_outside)
  );

  // ----------------------------------------------------------------------
  // xy to linear conversion
  // ----------------------------------------------------------------------
  // y shift is 31 minus control; out-of-range controls wrap in 5 bits
  wire logic [5:0] y_shift6 = `PITCH_SHIFT_BASE - pitch_shift_control[5:0];
  wire logic [4:0] y_shift  = y_shift6[4:0];
  // pixel size is one-hot; other values give shift zero
  logic [2:0] x_shift;
  always_comb begin
    case (pixel_width_setting)
      16'h0002: x_shift = 3'd1;
      16'h0004: x_shift = 3'd2;
      16'h0008: x_shift = 3'd3;
      16'h0010: x_shift = 3'd4;
      default:  x_shift = 3'd0;
    endcase
  end
  // sign of y kept by extension; x assumed positive
  wire logic [31:0] y_ext = {{16{req.source_register[31]}}, req.source_register[31:16]};
  wire logic [31:0] x_ext = {16'h0000, req.source_register[15:0]};
  wire logic [31:0] linear = ((y_ext << y_shift) | (x_ext << x_shift)) + screen_origin;

  // ----------------------------------------------------------------------
  // result select and flag register
  // ----------------------------------------------------------------------
  cwxy_pkg::result_t next_res;
  always_comb begin
    next_res.value    = 32'h0000_0000;
    next_res.write_en = 1'b0;
    next_res.flags    = flags;
    case (req.op)
      cwxy_pkg::compare_immediate_op: begin
        next_res.flags = imm_flags;
      end
      cwxy_pkg::compare_packed_coords_op: begin
        next_res.flags = xy_flags;
      end
      cwxy_pkg::window_point_code_op: begin
        next_res.value    = point_code;
        next_res.write_en = 1'b1;
        next_res.flags.v  = point_outside;
      end
      cwxy_pkg::coords_to_linear_op: begin
        next_res.value    = linear;
        next_res.write_en = 1'b1;
      end
      default: begin
        next_res.flags = flags;
      end
    endcase
  end

  // result and flags registered one cycle after the request
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      res       <= '0;
      res_valid <= 1'b0;
      flags     <= '0;
    end else begin
      res_valid <= req_valid;
      if (req_valid) begin
        res   <= next_res;
        flags <= next_res.flags;
      end
    end
  end
endmodule
`default_nettype wire

// ===== cwxy_unit_chk.sv
// checker for the result side of the compare / xy unit
// assumes it is bound to cwxy_unit and sees only its ports
`default_nettype none
module cwxy_unit_chk (
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               resetn,
  // instruction side
  input wire logic               req_valid,
  input wire cwxy_pkg::request_t req,
  input wire logic               res_valid,
  input wire cwxy_pkg::result_t  res
);
  // ------------------------------------------------------------
  // request decode, precomputed so $past only sees plain signals
  // ------------------------------------------------------------
  wire logic        ci = req_valid && req.op == cwxy_pkg::compare_immediate_op;
  wire logic        xy = req_valid && req.op == cwxy_pkg::compare_packed_coords_op;
  wire logic        cp = req_valid && req.op == cwxy_pkg::window_point_code_op;
  wire logic        ci_eq = req.destination_value == ~{req.imm_high_word, req.imm_low_word};
  wire logic        x_eq = req.destination_value[15:0] == req.source_register[15:0];
  wire logic [15:0] dx = req.destination_value[15:0] - req.source_register[15:0];
  wire logic [15:0] dy = req.destination_value[31:16] - req.source_register[31:16];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_answer_next: assert property (req_valid |=> res_valid)
    else $error("result pulse missing after request");
  a_answer_once: assert property (!req_valid |=> !res_valid)
    else $error("result pulse without request");
  a_compare_immediate_op_nowrite: assert property (ci |=> !res.write_en)
    else $error("long compare asked for a write");
  a_compare_immediate_op_zero: assert property (ci |=> res.flags.z == $past(ci_eq))
    else $error("long compare zero flag wrong");
  a_xy_nflag: assert property (xy |=> res.flags.n == $past(x_eq) && !res.write_en)
    else $error("xy compare n flag or write wrong");
  a_xy_signs: assert property (xy |=> res.flags.c == $past(dy[15])
                               && res.flags.v == $past(dx[15]))
    else $error("xy compare c or v flag wrong");
  a_code_zeros: assert property (cp |=> res.value[4:0] == 0 && res.value[31:9] == 0)
    else $error("point code has stray bits");
  a_code_vflag: assert property (cp |=> res.flags.v == (|res.value[8:5]) && res.write_en)
    else $error("point code v flag or write wrong");
  a_code_keep: assert property (cp |=> $stable(res.flags.n) && $stable(res.flags.c)
                                && $stable(res.flags.z))
    else $error("point code disturbed n c z");
endmodule

bind cwxy_unit cwxy_unit_chk chk (.sys_clk, .resetn, .req_valid, .req, .res_valid, .res);
`default_nettype wire

// ===== tb_compare_window_xy_unit.sv
// self-checking bench for the compare / xy unit
// assumes cwxy_pkg, cwxy_regs.svh and the checker are compiled first
`default_nettype none
`include "cwxy_regs.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_compare_window_xy_unit;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals and operand tables
  // ------------------------------------------------------------
  logic               sys_clk, resetn, psel, penable, pwrite, req_valid, err;
  logic        [31:0] paddr, pwdata, prdata, rd, d, e;
  logic               pready, pslverr, res_valid;
  logic        [15:0] dx, dy;
  cwxy_pkg::request_t req;
  cwxy_pkg::result_t  res;
  int                 failures, tests_run, i;
  logic [31:0] ra[6] = '{`PITCH_SHIFT_CONTROL_ADDR, `PIXEL_WIDTH_SETTING_ADDR,
    `WINDOW_LOW_CORNER_ADDR, `WINDOW_HIGH_CORNER_ADDR, `SCREEN_ORIGIN_ADDR, `STATUS_FLAGS_ADDR};
  logic [31:0] rv[6] = '{32'h0000_0014, 32'h0000_0001, 0, 0, 0, 0};
  logic [31:0] ci_imm[7] = '{32'h8000, 32'h8000, 32'h8000, 32'h8000, 32'h8000,
    32'hFFFF_7FFF, 32'hFFFF_7FFF};
  logic [31:0] ci_dst[7] = '{32'h8001, 32'h8000, 32'h7FFF, 32'hFFFF_FFFF, 32'h8000_7FFF,
    32'h0, 32'h7FFF_7FFF};
  logic [3:0]  ci_f[7] = '{4'h0, 4'h2, 4'hC, 4'h8, 4'h1, 4'h4, 4'hD};
  logic [31:0] xy_dst[6] = '{32'h0001_0001, 32'h0009_0009, 32'h0010_0010, 32'h0009_0010,
    32'h8000_0009, 32'h0009_FFFF};
  logic [31:0] pt[8] = '{32'h0004_0004, 32'h0004_000B, 32'h0005_0004, 32'h0005_0005,
    32'h000A_000A, 32'h000A_000B, 32'h000B_0004, 32'h000B_000B};
  logic [31:0] cd[8] = '{32'hA0, 32'hC0, 32'h20, 0, 0, 32'h40, 32'h120, 32'h140};

  cwxy_unit dut (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
                 .pready, .pslverr, .req_valid, .req, .res_valid, .res);

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  // verdict and end of run
  task automatic wrap_up;
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one instruction; imm is the plain value, sent as inverted words
  task automatic run(input cwxy_pkg::op_t op, input logic [31:0] imm, s, dv);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= '{op, ~imm[15:0], ~imm[31:16], s, dv};
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1 `CHK(res_valid, 1'b1)
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {sys_clk, resetn, psel, penable, pwrite, req_valid} = '0;
    {paddr, pwdata} = '0;
    req = '0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    // reset values, then an unmapped access that must be refused
    foreach (ra[k]) begin
      apb(1'b0, ra[k], 0);
      `CHK(rd, rv[k])
    end
    apb(1'b0, 32'h0000_0010, 0);
    `CHK({err, rd}, 33'h1_0000_0000)
    // long compare over sign and borrow corners
    for (i = 0; i < 7; i++) begin
      run(cwxy_pkg::compare_immediate_op, ci_imm[i], 0, ci_dst[i]);
      `CHK(res.flags, ci_f[i])
      `CHK(res.write_en, 1'b0)
    end
    // xy compare; expectation built per half, wrap of the sign included
    for (i = 0; i < 6; i++) begin
      d = xy_dst[i];
      dx = d[15:0] - 16'h0009;
      dy = d[31:16] - 16'h0009;
      run(cwxy_pkg::compare_packed_coords_op, 0, 32'h0009_0009, d);
      `CHK(res.flags, {d[15:0] == 16'h9, dy[15], d[31:16] == 16'h9, dx[15]})
      `CHK(res.write_en, 1'b0)
    end
    // point code against a 6 x 6 window; n c z preset to 110
    apb(1'b1, `WINDOW_LOW_CORNER_ADDR, 32'h0005_0005);
    apb(1'b1, `WINDOW_HIGH_CORNER_ADDR, 32'h000A_000A);
    run(cwxy_pkg::compare_immediate_op, 32'hFFFF_7FFF, 0, 32'h7FFF_7FFF);
    for (i = 0; i < 8; i++) begin
      run(cwxy_pkg::window_point_code_op, 0, pt[i], 32'hFFFF_FFFF);
      `CHK(res.value, cd[i])
      `CHK(res.flags, {3'b110, cd[i] != 0})
    end
    // xy to linear over every pixel size and several pitches
    for (i = 0; i < 5; i++) begin
      apb(1'b1, `PITCH_SHIFT_CONTROL_ADDR, 32'h0000_0012 + i);
      apb(1'b1, `SCREEN_ORIGIN_ADDR, i << 24);
      apb(1'b1, `PIXEL_WIDTH_SETTING_ADDR, 1 << i);
      apb(1'b0, `PIXEL_WIDTH_SETTING_ADDR, 0);
      `CHK(rd, 32'(1 << i))
      run(cwxy_pkg::coords_to_linear_op, 0, 32'h0040_0030, 0);
      e = ((32'h0000_0040 << (13 - i)) | (32'h0000_0030 << i)) + (i << 24);
      `CHK(res.value, e)
    end
    wrap_up();
  end
endmodule
`default_nettype wire
